/* src/bwg_cfg.svh */
// register offsets, field positions, reset values and the rule overview
//
// Overview of operation
// - limit field 31:20 read/write, reset value 000FFFFFh
// - bits 19:16 read-only, report 64-bit window
// - offset 54h holds upper base, reset zero
// - offset 58h holds upper limit, reset zero
// - unmasked event with report enable pulses error
// - mask bit 1 gates posted write parity
// - bits 2, 5 gate write non-delivery
// - mask bit 3 gates posted write target abort
// - mask bit 4 gates posted write master abort
// - mask bit 6 gates delayed read no data
// - reserved mask and gpio bits read zero
// - clear field drives enabled pin low
// - set field drives enabled pin high
// - new level shows cycle after write
// - input-only pins stay undriven
// - enable clear field makes pin input only
// - enable set field makes pin drive data
// - bits 31:28 show sampled pin state
// - window enable bit confines upstream forwarding
// - offset 50h bits 15:4 hold base
`ifndef BWG_CFG_SVH
`define BWG_CFG_SVH

`define BWG_OFF_UPCTL      8'h48
`define BWG_OFF_UPLIM      8'h50
`define BWG_OFF_UPBASE_HI  8'h54
`define BWG_OFF_UPLIM_HI   8'h58
`define BWG_OFF_MASK_GPIO  8'h64

`define BWG_UPCTL_EN_BIT   16
`define BWG_UPLIM_RST      32'h000FFFFF
`define BWG_UP64_FLAG      4'h1
`define BWG_UPBASE_RST     12'h000
`define BWG_UPHI_RST       32'h0000_0000
`define BWG_MASK_RST       6'h00
`define BWG_GPIO_RST       4'h0
`define BWG_WIN_LOW_BITS   20
`define BWG_WIN_LOW_ONES   20'hFFFFF

`endif

/* src/bwg_pkg.sv */
// types shared by the bridge register slice
package bwg_pkg;

  // one configuration access, taken in a single cycle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bwg_cfg_req_s;

  // one-cycle event pulses, bit order matches mask bits 6:1
  typedef struct packed {
    logic dr_no_data;
    logic dw_no_delivery;
    logic pw_master_abort;
    logic pw_target_abort;
    logic pw_no_delivery;
    logic pw_parity;
  } bwg_err_evt_s;

endpackage

/* src/bwg_gpio_bit.sv */
// one general-purpose pin: output data, driver enable and input sampler
`timescale 1ns/10ps
module bwg_gpio_bit
(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // strobes from a configuration write
  input  wire logic out_set_i,
  input  wire logic out_clr_i,
  input  wire logic oe_set_i,
  input  wire logic oe_clr_i,
  // pin
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe_n_o,
  output logic      pin_sync_o
);

  // set wins when software hits both halves at once
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      pin_o <= 1'b0;
    else if (out_set_i)
      pin_o <= 1'b1;
    else if (out_clr_i)
      pin_o <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      pin_oe_n_o <= 1'b1;
    else if (oe_set_i)
      pin_oe_n_o <= 1'b0;
    else if (oe_clr_i)
      pin_oe_n_o <= 1'b1;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      pin_sync_o <= 1'b0;
    else
      pin_sync_o <= pin_i;
  end

endmodule // bwg_gpio_bit

/* src/bwg_regs.sv */
// upstream window, error mask and gpio configuration registers
`timescale 1ns/10ps
`include "bwg_cfg.svh"
module bwg_regs
#(
  parameter int GPIO_W = 4
)
(
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // configuration access
  input  wire bwg_pkg::bwg_cfg_req_s cfg_req_i,
  output logic [31:0]                cfg_rdata_o,
  output logic                       cfg_rvalid_o,
  // error events and command register enable
  input  wire bwg_pkg::bwg_err_evt_s err_evt_i,
  input  wire logic                  error_report_enable_i,
  // primary system error, open drain
  output logic                       primary_system_error_n_o,
  output logic                       primary_system_error_oe_n_o,
  // upstream window check
  input  wire logic [63:0]           up_addr_i,
  input  wire logic                  downstream_hit_i,
  output logic                       up_in_window_o,
  // general-purpose pins
  input  wire logic [GPIO_W-1:0]     gpio_i,
  output logic [GPIO_W-1:0]          gpio_o,
  output logic [GPIO_W-1:0]          gpio_oe_n_o
);

  // register state
  logic                  up_win_en;
  logic [11:0]           up_base;
  logic [11:0]           up_limit;
  logic [31:0]           up_base_hi;
  logic [31:0]           up_limit_hi;
  logic [5:0]            err_mask;
  logic [GPIO_W-1:0]     f_out_clr;
  logic [GPIO_W-1:0]     f_out_set;
  logic [GPIO_W-1:0]     f_oe_clr;
  logic [GPIO_W-1:0]     f_oe_set;
  logic [GPIO_W-1:0]     gpio_sync;

  // decode
  logic                  hit_ctl;
  logic                  hit_lim;
  logic                  hit_base_hi;
  logic                  hit_lim_hi;
  logic                  hit_mg;
  logic                  wr_ctl;
  logic                  wr_lim;
  logic                  wr_base_hi;
  logic                  wr_lim_hi;
  logic                  wr_mg;

  // gpio write strobes
  logic [GPIO_W-1:0]     stb_out_clr;
  logic [GPIO_W-1:0]     stb_out_set;
  logic [GPIO_W-1:0]     stb_oe_clr;
  logic [GPIO_W-1:0]     stb_oe_set;

  // error signalling
  logic [5:0]            evt_vec;
  logic                  next_serr;

  // window check
  logic [43:0]           win_addr;
  logic [43:0]           win_base;
  logic [43:0]           win_limit;

  // read path
  logic [31:0]           next_rdata;

  // byte-lane merge for plain read/write registers
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // word index only: byte offsets are cut to the 6 compared address bits
  assign hit_ctl     = (cfg_req_i.addr[7:2] == 6'(`BWG_OFF_UPCTL     >> 2));
  assign hit_lim     = (cfg_req_i.addr[7:2] == 6'(`BWG_OFF_UPLIM     >> 2));
  assign hit_base_hi = (cfg_req_i.addr[7:2] == 6'(`BWG_OFF_UPBASE_HI >> 2));
  assign hit_lim_hi  = (cfg_req_i.addr[7:2] == 6'(`BWG_OFF_UPLIM_HI  >> 2));
  assign hit_mg      = (cfg_req_i.addr[7:2] == 6'(`BWG_OFF_MASK_GPIO >> 2));

  assign wr_ctl      = cfg_req_i.wr && hit_ctl;
  assign wr_lim      = cfg_req_i.wr && hit_lim;
  assign wr_base_hi  = cfg_req_i.wr && hit_base_hi;
  assign wr_lim_hi   = cfg_req_i.wr && hit_lim_hi;
  assign wr_mg       = cfg_req_i.wr && hit_mg;

  // window enable, only bit 16 of its word is kept here
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      up_win_en <= 1'b0;
    else if (wr_ctl && cfg_req_i.be[2])
      up_win_en <= cfg_req_i.wdata[`BWG_UPCTL_EN_BIT];
  end

  // base in 15:4, limit in 31:20; the flag nibbles are constants
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      up_base  <= `BWG_UPBASE_RST;
      up_limit <= 12'(`BWG_UPLIM_RST >> 20);
    end
    else if (wr_lim)
    begin
      if (cfg_req_i.be[0])
        up_base[3:0] <= cfg_req_i.wdata[7:4];
      if (cfg_req_i.be[1])
        up_base[11:4] <= cfg_req_i.wdata[15:8];
      if (cfg_req_i.be[2])
        up_limit[3:0] <= cfg_req_i.wdata[23:20];
      if (cfg_req_i.be[3])
        up_limit[11:4] <= cfg_req_i.wdata[31:24];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      up_base_hi <= `BWG_UPHI_RST;
    else if (wr_base_hi)
      up_base_hi <= merge_be(up_base_hi, cfg_req_i.wdata, cfg_req_i.be);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      up_limit_hi <= `BWG_UPHI_RST;
    else if (wr_lim_hi)
      up_limit_hi <= merge_be(up_limit_hi, cfg_req_i.wdata, cfg_req_i.be);
  end

  // mask bits 6:1 live in byte 0; bits 0 and 7 are not stored
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      err_mask <= `BWG_MASK_RST;
    else if (wr_mg && cfg_req_i.be[0])
      err_mask <= cfg_req_i.wdata[6:1];
  end

  // gpio fields read back the last value written to them
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      f_out_clr <= `BWG_GPIO_RST;
      f_out_set <= `BWG_GPIO_RST;
    end
    else if (wr_mg && cfg_req_i.be[1])
    begin
      f_out_clr <= cfg_req_i.wdata[8 +: GPIO_W];
      f_out_set <= cfg_req_i.wdata[12 +: GPIO_W];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      f_oe_clr <= `BWG_GPIO_RST;
      f_oe_set <= `BWG_GPIO_RST;
    end
    else if (wr_mg && cfg_req_i.be[2])
    begin
      f_oe_clr <= cfg_req_i.wdata[16 +: GPIO_W];
      f_oe_set <= cfg_req_i.wdata[20 +: GPIO_W];
    end
  end

  // only ones act; zeros leave the pin as it was
  assign stb_out_clr = (wr_mg && cfg_req_i.be[1]) ? cfg_req_i.wdata[8 +: GPIO_W]  : '0;
  assign stb_out_set = (wr_mg && cfg_req_i.be[1]) ? cfg_req_i.wdata[12 +: GPIO_W] : '0;
  assign stb_oe_clr  = (wr_mg && cfg_req_i.be[2]) ? cfg_req_i.wdata[16 +: GPIO_W] : '0;
  assign stb_oe_set  = (wr_mg && cfg_req_i.be[2]) ? cfg_req_i.wdata[20 +: GPIO_W] : '0;

  for (genvar g = 0; g < GPIO_W; g++)
  begin : g_pin
    bwg_gpio_bit u_pin
    (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .out_set_i  (stb_out_set[g]),
      .out_clr_i  (stb_out_clr[g]),
      .oe_set_i   (stb_oe_set[g]),
      .oe_clr_i   (stb_oe_clr[g]),
      .pin_i      (gpio_i[g]),
      .pin_o      (gpio_o[g]),
      .pin_oe_n_o (gpio_oe_n_o[g]),
      .pin_sync_o (gpio_sync[g])
    );
  end

  // error pulse: one cycle low per cycle with an unmasked event
  assign evt_vec   = err_evt_i;
  assign next_serr = error_report_enable_i && |(evt_vec & ~err_mask);

  // open drain: data low and driver on together, released otherwise
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      primary_system_error_n_o    <= 1'b1;
      primary_system_error_oe_n_o <= 1'b1;
    end
    else
    begin
      primary_system_error_n_o    <= ~next_serr;
      primary_system_error_oe_n_o <= ~next_serr;
    end
  end

  // window compare on address bits 63:20; lower bits don't care
  assign win_addr  = up_addr_i[63:`BWG_WIN_LOW_BITS];
  assign win_base  = {up_base_hi, up_base};
  assign win_limit = {up_limit_hi, up_limit};

  always_comb
  begin
    if (up_win_en)
      up_in_window_o = (win_addr >= win_base) && (win_addr <= win_limit);
    else
      up_in_window_o = !downstream_hit_i;
  end

  // read mux; unmapped offsets return zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (1'b1)
      hit_ctl:
        next_rdata[`BWG_UPCTL_EN_BIT] = up_win_en;
      hit_lim:
        next_rdata = {up_limit, `BWG_UP64_FLAG, up_base, `BWG_UP64_FLAG};
      hit_base_hi:
        next_rdata = up_base_hi;
      hit_lim_hi:
        next_rdata = up_limit_hi;
      hit_mg:
      begin
        next_rdata[6:1]                = err_mask;
        next_rdata[8 +: GPIO_W]        = f_out_clr;
        next_rdata[12 +: GPIO_W]       = f_out_set;
        next_rdata[16 +: GPIO_W]       = f_oe_clr;
        next_rdata[20 +: GPIO_W]       = f_oe_set;
        next_rdata[28 +: GPIO_W]       = gpio_sync;
      end
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_rdata_o <= 32'h0000_0000;
    else if (cfg_req_i.rd)
      cfg_rdata_o <= next_rdata;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_rvalid_o <= 1'b0;
    else
      cfg_rvalid_o <= cfg_req_i.rd;
  end

endmodule // bwg_regs

/* sim/bwg_board.sv */
// board logic facing the general-purpose pins
`timescale 1ns/10ps
module bwg_board
(
  // bridge side
  input  wire logic [3:0] drv_i,
  input  wire logic [3:0] drv_oe_n_i,
  // board side
  input  wire logic [3:0] lvl_i,
  output logic      [3:0] pin_o
);
  // a released pin settles to the board level, never to the last driven value
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      pin_o[b] = drv_oe_n_i[b] ? lvl_i[b] : drv_i[b];
  end
endmodule // bwg_board

/* sim/bwg_regs_assertions.sv */
// port checker for the bridge register slice
`timescale 1ns/10ps
module bwg_regs_chk
#(
  parameter int GPIO_W = 4
)
(
  // clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  rst_i,
  // watched ports
  input wire bwg_pkg::bwg_cfg_req_s cfg_req_i,
  input wire logic [31:0]           cfg_rdata_o,
  input wire bwg_pkg::bwg_err_evt_s err_evt_i,
  input wire logic                  error_report_enable_i,
  input wire logic                  primary_system_error_n_o,
  input wire logic                  primary_system_error_oe_n_o,
  input wire logic [GPIO_W-1:0]     gpio_i,
  input wire logic [GPIO_W-1:0]     gpio_o,
  input wire logic [GPIO_W-1:0]     gpio_oe_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic w64;
  logic r64;
  assign w64 = cfg_req_i.wr && cfg_req_i.addr[7:2] == 6'h19;
  assign r64 = cfg_req_i.rd && cfg_req_i.addr[7:2] == 6'h19;
  property p_off;
    !error_report_enable_i |=> primary_system_error_n_o;
  endproperty
  a_off: assert property (p_off) else $error("error pulse with reporting off");
  property p_quiet;
    err_evt_i == 6'h00 |=> primary_system_error_n_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("error pulse without event");
  property p_oe;
    primary_system_error_oe_n_o == primary_system_error_n_o;
  endproperty
  a_oe: assert property (p_oe) else $error("error pin enable differs from level");
  property p_out;
    w64 && cfg_req_i.be[1] |=> gpio_o == (($past(gpio_o) & ~$past(cfg_req_i.wdata[11:8]))
      | $past(cfg_req_i.wdata[15:12]));
  endproperty
  a_out: assert property (p_out) else $error("pin data not set or cleared");
  property p_out_hold;
    !(w64 && cfg_req_i.be[1]) |=> $stable(gpio_o);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("pin data moved without write");
  property p_en;
    w64 && cfg_req_i.be[2] |=> gpio_oe_n_o == (($past(gpio_oe_n_o) | $past(cfg_req_i.wdata[19:16]))
      & ~$past(cfg_req_i.wdata[23:20]));
  endproperty
  a_en: assert property (p_en) else $error("pin enable not set or cleared");
  property p_en_hold;
    !(w64 && cfg_req_i.be[2]) |=> $stable(gpio_oe_n_o);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("pin enable moved without write");
  property p_flag;
    cfg_req_i.rd && cfg_req_i.addr[7:2] == 6'h14 |=> cfg_rdata_o[19:16] == 4'h1;
  endproperty
  a_flag: assert property (p_flag) else $error("64-bit flag not read as 1");
  property p_rsv;
    r64 |=> cfg_rdata_o[27:24] == 4'h0 && !cfg_rdata_o[7] && !cfg_rdata_o[0];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_in;
    r64 && $stable(gpio_i) && !$past(rst_i) |=> cfg_rdata_o[31:28] == $past(gpio_i);
  endproperty
  a_in: assert property (p_in) else $error("pin state not reported");
endmodule // bwg_regs_chk

bind bwg_regs bwg_regs_chk #(.GPIO_W(GPIO_W)) u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_req_i(cfg_req_i),
  .cfg_rdata_o(cfg_rdata_o), .err_evt_i(err_evt_i), .error_report_enable_i(error_report_enable_i),
  .primary_system_error_n_o(primary_system_error_n_o), .primary_system_error_oe_n_o(primary_system_error_oe_n_o),
  .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_n_o(gpio_oe_n_o));

/* sim/bwg_regs_test.sv */
// self-checking bench for the bridge register slice
`timescale 1ns/10ps
module bwg_regs_test;
  logic                  clk_sys_i = 1'b0;
  logic                  rst_i = 1'b1;
  bwg_pkg::bwg_cfg_req_s cfg_req_i = '0;
  bwg_pkg::bwg_err_evt_s err_evt_i = '0;
  logic                  error_report_enable_i = 1'b0;
  logic [63:0]           up_addr_i = '0;
  logic                  downstream_hit_i = 1'b0;
  logic [3:0]            board_lvl = 4'h0;
  logic [31:0]           cfg_rdata_o;
  logic                  cfg_rvalid_o;
  logic                  serr_n;
  logic                  serr_oe_n;
  logic                  up_in_window_o;
  logic [3:0]            gpio_i;
  logic [3:0]            gpio_o;
  logic [3:0]            gpio_oe_n_o;
  int                    fails = 0;
  int                    n_compared = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  bwg_regs #(.GPIO_W(4)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_req_i(cfg_req_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .err_evt_i(err_evt_i),
    .error_report_enable_i(error_report_enable_i), .primary_system_error_n_o(serr_n),
    .primary_system_error_oe_n_o(serr_oe_n), .up_addr_i(up_addr_i), .downstream_hit_i(downstream_hit_i),
    .up_in_window_o(up_in_window_o), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_n_o(gpio_oe_n_o));
  bwg_board u_board (.drv_i(gpio_o), .drv_oe_n_i(gpio_oe_n_o), .lvl_i(board_lvl), .pin_o(gpio_i));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_req_i <= '{1'b1, 1'b0, a, be, d};
    @(posedge clk_sys_i);
    cfg_req_i <= '0;
    @(posedge clk_sys_i);
  endtask

  // read data stands until the next read, rvalid only one cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    cfg_req_i <= '{1'b0, 1'b1, a, 4'hF, 32'h0};
    @(posedge clk_sys_i);
    cfg_req_i <= '0;
    #1;
    chk("rvalid", 32'h1, {31'h0, cfg_rvalid_o});
    chk($sformatf("reg %h", a), exp, cfg_rdata_o & msk);
    @(posedge clk_sys_i);
  endtask

  task automatic ev(input int i, input logic exp_n);
    err_evt_i <= bwg_pkg::bwg_err_evt_s'(6'h01 << i);
    @(posedge clk_sys_i);
    err_evt_i <= '0;
    #1;
    chk("error pin", {31'h0, exp_n}, {31'h0, serr_n});
    chk("error enable", {31'h0, exp_n}, {31'h0, serr_oe_n});
    @(posedge clk_sys_i);
  endtask

  task automatic win(input logic [63:0] a, input logic h, input logic exp);
    up_addr_i <= a;
    downstream_hit_i <= h;
    @(posedge clk_sys_i);
    #1;
    chk("in window", {31'h0, exp}, {31'h0, up_in_window_o});
    @(posedge clk_sys_i);
  endtask

  task automatic t_reset;
    rd(8'h50, 32'hFFFFFFFF, 32'h00010001);
    rd(8'h54, 32'hFFFFFFFF, 32'h0);
    rd(8'h58, 32'hFFFFFFFF, 32'h0);
    rd(8'h64, 32'h0FFFFFFF, 32'h0);
    rd(8'h48, 32'hFFFFFFFF, 32'h0);
    rd(8'h7C, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_win_regs;
    wr(8'h50, 4'hF, 32'hFFFFFFFF);
    rd(8'h50, 32'hFFFFFFFF, 32'hFFF1FFF1);
    wr(8'h54, 4'hF, 32'hA5A55A5A);
    wr(8'h54, 4'h1, 32'h0);
    rd(8'h54, 32'hFFFFFFFF, 32'hA5A55A00);
    wr(8'h58, 4'hF, 32'h5A5AA5A5);
    rd(8'h58, 32'hFFFFFFFF, 32'h5A5AA5A5);
  endtask

  task automatic t_window;
    wr(8'h50, 4'hF, 32'h00200010);
    wr(8'h54, 4'hF, 32'h1);
    wr(8'h58, 4'hF, 32'h1);
    wr(8'h48, 4'h4, 32'h00010000);
    rd(8'h48, 32'hFFFFFFFF, 32'h00010000);
    win(64'h1_000F_FFFF, 1'b0, 1'b0);
    win(64'h1_0010_0000, 1'b1, 1'b1);
    win(64'h1_002F_FFFF, 1'b0, 1'b1);
    win(64'h1_0030_0000, 1'b0, 1'b0);
    win(64'h0_0010_0000, 1'b0, 1'b0);
    win(64'h2_0010_0000, 1'b0, 1'b0);
    wr(8'h48, 4'h4, 32'h0);
    win(64'h1_0010_0000, 1'b1, 1'b0);
    win(64'h1_0030_0000, 1'b0, 1'b1);
  endtask

  task automatic t_serr;
    error_report_enable_i <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      ev(i, 1'b0);
      wr(8'h64, 4'h1, 32'h2 << i);
      ev(i, 1'b1);
    end
    wr(8'h64, 4'h1, 32'hFF);
    rd(8'h64, 32'h000000FF, 32'h0000007E);
    wr(8'h64, 4'h1, 32'h0);
    error_report_enable_i <= 1'b0;
    ev(0, 1'b1);
  endtask

  task automatic t_gpio;
    wr(8'h64, 4'h4, 32'h00500000);
    chk("pin enable", 32'hA, {28'h0, gpio_oe_n_o});
    wr(8'h64, 4'h2, 32'h0000F000);
    chk("pin data", 32'hF, {28'h0, gpio_o});
    rd(8'h64, 32'hF0FFFF00, 32'h5050F000);
    wr(8'h64, 4'h2, 32'h00000100);
    chk("pin data", 32'hE, {28'h0, gpio_o});
    wr(8'h64, 4'h6, 32'h0);
    chk("pin data", 32'hE, {28'h0, gpio_o});
    wr(8'h64, 4'h4, 32'h00040000);
    chk("pin enable", 32'hE, {28'h0, gpio_oe_n_o});
    board_lvl <= 4'hF;
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    rd(8'h64, 32'hF0000000, 32'hE0000000);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // a hang is cut short here and counted against the run
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    fails++;
    results();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_win_regs();
    t_window();
    t_serr();
    t_gpio();
    results();
  end
endmodule // bwg_regs_test
